// file: hw/tws_slave.v
/*
 tws_slave: two-wire serial slave fronting an 8,192 x 8 memory: slave address
 match, two-byte address latch with auto-increment, sequential writes and
 no-acknowledge-terminated sequential reads, write protection of the top quarter.
 assumes scl_in and sda_in are the wire levels, asynchronous to sys_clk, and
 that the bus clock is slow enough for several sys_clk cycles per phase.
*/
// Summary of operation
// R1: 8,192 locations; only lower 13 of 16 address bits decoded.
// R2: master should send zeros in the three unused upper address bits.
// R3: byte writes finish within the serial transfer; no ready polling.
// R4: start is data falling while clock high; commands begin with it.
// R5: a start anywhere aborts and waits for a slave address.
// R6: stop is data rising while clock high; ends or aborts any operation.
// R7: master issues stop only while it owns the data line.
// R8: data sampled while clock high; stable then except start and stop.
// R9: after eighth bit transmitter releases, receiver pulls low one clock.
// R10: no pull-down in acknowledge slot means no-acknowledge; abort.
// R11: master withholds acknowledge on the last wanted read byte.
// R12: first byte after start is slave address; upper nibble type code.
// R13: address bits three to one must match device select pins.
// R14: address bit zero: zero write, one read.
// R15: write sends high then low address byte into the latch.
// R16: latch holds until rewritten and advances after each access.
// R17: every read starts at the current latched address.
// R18: increment before acknowledge slot, wrap top to zero, unlimited bytes.
// R19: read shifts eight bits, samples acknowledge, continues or ends.
// R20: write receives eight bits then drives an acknowledge.
// R21: all bytes move most significant bit first.
// R22: protect pin high: no ack, no increment for top-quarter writes.
// R23: array write after eighth data bit; earlier abort leaves memory.
// R24: selective read: write address, repeated start, then current read.
// R25: clock and data synchronised and sampled; edges give events.
// R26: reset enters idle, releases data line, waits for start.
`timescale 1ns/100ps
`default_nettype none

`include "tws_map.vh"

module tws_slave #(
   // device-type code; value arbitrary
   parameter [3:0] TYPE_CODE = 4'h6
) (
   input  wire                    sys_clk,
   input  wire                    reset,
   input  wire                    scl_in,
   input  wire                    sda_in,
   output reg                     sda_out_ff,
   output reg                     sda_oe_ff,
   input  wire [2:0]              device_select_pins,
   input  wire                    write_protect,
   output reg  [`TWS_ADDR_W-1:0]  cur_addr_ff,
   output reg                     busy_ff
);

   localparam [2:0] ST_IDLE  = 3'h0;
   localparam [2:0] ST_RX    = 3'h1;
   localparam [2:0] ST_RXACK = 3'h2;
   localparam [2:0] ST_TX    = 3'h3;
   localparam [2:0] ST_TXACK = 3'h4;

   localparam [1:0] K_DEV    = 2'h0;
   localparam [1:0] K_AHI    = 2'h1;
   localparam [1:0] K_ALO    = 2'h2;
   localparam [1:0] K_DATA   = 2'h3;

   // synchronisers and previous samples
   reg                     scl_meta_ff;
   reg                     scl_sync_ff;
   reg                     scl_prev_ff;
   reg                     sda_meta_ff;
   reg                     sda_sync_ff;
   reg                     sda_prev_ff;

   // protocol state
   reg  [2:0]              state_ff;
   reg  [1:0]              kind_ff;
   reg  [3:0]              cnt_ff;
   reg  [7:0]              rx_sh_ff;
   reg  [7:0]              tx_sh_ff;
   reg                     rw_ff;
   reg  [4:0]              addr_hi_ff;

   reg  [2:0]              nxt_state;
   reg  [1:0]              nxt_kind;
   reg  [3:0]              nxt_cnt;
   reg  [7:0]              nxt_rx_sh;
   reg  [7:0]              nxt_tx_sh;
   reg                     nxt_rw;
   reg  [4:0]              nxt_addr_hi;
   reg  [`TWS_ADDR_W-1:0]  nxt_addr;
   reg                     nxt_oe;
   reg                     mem_we;

   wire                    scl_rise;
   wire                    scl_fall;
   wire                    start_det;
   wire                    stop_det;
   wire                    dev_match;
   wire                    prot_hit;
   wire [`TWS_ADDR_W-1:0]  addr_inc;
   wire [7:0]              rd_data;

   // two stages before anything looks at the lines; meta stage read only by sync
   always @(posedge sys_clk) begin
      if (reset) begin
         scl_meta_ff <= 1'b1;
         scl_sync_ff <= 1'b1;
         scl_prev_ff <= 1'b1;
         sda_meta_ff <= 1'b1;
         sda_sync_ff <= 1'b1;
         sda_prev_ff <= 1'b1;
      end else begin
         scl_meta_ff <= scl_in;        // [R25]
         scl_sync_ff <= scl_meta_ff;   // [R25]
         scl_prev_ff <= scl_sync_ff;
         sda_meta_ff <= sda_in;        // [R25]
         sda_sync_ff <= sda_meta_ff;   // [R25]
         sda_prev_ff <= sda_sync_ff;
      end
   end

   assign scl_rise  = scl_sync_ff & ~scl_prev_ff;                               // [R25] [R8]
   assign scl_fall  = ~scl_sync_ff & scl_prev_ff;                               // [R25]
   assign start_det = scl_sync_ff & scl_prev_ff & sda_prev_ff & ~sda_sync_ff;   // [R4]
   assign stop_det  = scl_sync_ff & scl_prev_ff & ~sda_prev_ff & sda_sync_ff;   // [R6]

   // type nibble and select pins both must agree
   assign dev_match = (rx_sh_ff[`TWS_SA_TYPE_HI:`TWS_SA_TYPE_LO] == TYPE_CODE) &&          // [R12]
                      (rx_sh_ff[`TWS_SA_SEL_HI:`TWS_SA_SEL_LO] == device_select_pins);     // [R13]

   assign prot_hit  = write_protect && (cur_addr_ff >= `TWS_PROT_BASE);           // [R22]

   // wrap from top to zero explicitly
   assign addr_inc  = (cur_addr_ff == `TWS_ADDR_TOP) ? `TWS_ADDR_ZERO :
                      (cur_addr_ff + `TWS_ADDR_ONE);                             // [R18]

   always @* begin
      nxt_state   = state_ff;
      nxt_kind    = kind_ff;
      nxt_cnt     = cnt_ff;
      nxt_rx_sh   = rx_sh_ff;
      nxt_tx_sh   = tx_sh_ff;
      nxt_rw      = rw_ff;
      nxt_addr_hi = addr_hi_ff;
      nxt_addr    = cur_addr_ff;
      nxt_oe      = sda_oe_ff;
      mem_we      = 1'b0;
      if (stop_det) begin
         // master only stops while it owns the line, so release is safe
         nxt_state = ST_IDLE;                                                    // [R6] [R7]
         nxt_oe    = 1'b0;
      end else if (start_det) begin
         // also serves as the repeated start of a selective read
         nxt_state = ST_RX;                                                      // [R5] [R24]
         nxt_kind  = K_DEV;                                                      // [R12]
         nxt_cnt   = `TWS_CNT_ZERO;
         nxt_oe    = 1'b0;
      end else begin
         case (state_ff)
            ST_IDLE: begin
               nxt_oe = 1'b0;                                                    // [R26]
            end
            ST_RX: begin
               if (scl_rise && (cnt_ff != `TWS_BITS_PER_BYTE)) begin
                  nxt_rx_sh = {rx_sh_ff[6:0], sda_sync_ff};                      // [R21] [R8]
                  nxt_cnt   = cnt_ff + `TWS_CNT_ONE;
               end else if (scl_fall && (cnt_ff == `TWS_BITS_PER_BYTE)) begin
                  case (kind_ff)
                     K_DEV: begin
                        if (dev_match) begin
                           nxt_rw    = rx_sh_ff[`TWS_SA_RW_BIT];                 // [R14]
                           nxt_oe    = 1'b1;                                     // [R9]
                           nxt_state = ST_RXACK;
                        end else begin
                           nxt_state = ST_IDLE;                                  // [R12] [R13]
                        end
                     end
                     K_AHI: begin
                        // upper three bits dropped here
                        nxt_addr_hi = rx_sh_ff[`TWS_AHI_USED_HI:0];              // [R1] [R15]
                        nxt_oe      = 1'b1;                                      // [R9]
                        nxt_state   = ST_RXACK;
                     end
                     K_ALO: begin
                        nxt_addr  = {addr_hi_ff, rx_sh_ff};                      // [R15] [R16]
                        nxt_oe    = 1'b1;                                        // [R9]
                        nxt_state = ST_RXACK;
                     end
                     default: begin
                        if (prot_hit) begin
                           // no ack and no increment; the transfer ends here
                           nxt_state = ST_IDLE;                                  // [R22]
                        end else begin
                           mem_we    = 1'b1;                                     // [R23] [R3]
                           nxt_addr  = addr_inc;                                 // [R18] [R16]
                           nxt_oe    = 1'b1;                                     // [R20] [R9]
                           nxt_state = ST_RXACK;
                        end
                     end
                  endcase
               end
            end
            ST_RXACK: begin
               if (scl_fall) begin
                  if (rw_ff && (kind_ff == K_DEV)) begin
                     // first read bit goes out as the ack slot ends
                     nxt_oe    = ~rd_data[7];                                    // [R17] [R21]
                     nxt_tx_sh = {rd_data[6:0], 1'b1};
                     nxt_cnt   = `TWS_CNT_ONE;
                     nxt_state = ST_TX;
                  end else begin
                     nxt_oe    = 1'b0;                                           // [R9]
                     nxt_cnt   = `TWS_CNT_ZERO;
                     nxt_state = ST_RX;
                     case (kind_ff)
                        K_DEV:   nxt_kind = K_AHI;                               // [R15]
                        K_AHI:   nxt_kind = K_ALO;                               // [R15]
                        default: nxt_kind = K_DATA;                              // [R18]
                     endcase
                  end
               end
            end
            ST_TX: begin
               if (scl_fall) begin
                  if (cnt_ff == `TWS_BITS_PER_BYTE) begin
                     // release for the master's ack, advance just before it
                     nxt_oe    = 1'b0;                                           // [R9] [R19]
                     nxt_addr  = addr_inc;                                       // [R18] [R16]
                     nxt_state = ST_TXACK;
                  end else begin
                     nxt_oe    = ~tx_sh_ff[7];                                   // [R21] [R19]
                     nxt_tx_sh = {tx_sh_ff[6:0], 1'b1};
                     nxt_cnt   = cnt_ff + `TWS_CNT_ONE;
                  end
               end
            end
            ST_TXACK: begin
               if (scl_rise && sda_sync_ff) begin
                  // no-ack ends the read, line stays released
                  nxt_state = ST_IDLE;                                           // [R10] [R19] [R11]
               end else if (scl_fall) begin
                  // read data already refetched from the advanced address
                  nxt_oe    = ~rd_data[7];                                       // [R19] [R17]
                  nxt_tx_sh = {rd_data[6:0], 1'b1};
                  nxt_cnt   = `TWS_CNT_ONE;
                  nxt_state = ST_TX;
               end
            end
            default: begin
               nxt_state = ST_IDLE;
               nxt_oe    = 1'b0;
            end
         endcase
      end
   end

   always @(posedge sys_clk) begin
      if (reset) begin
         state_ff    <= ST_IDLE;                                                 // [R26]
         kind_ff     <= K_DEV;
         cnt_ff      <= `TWS_CNT_ZERO;
         rx_sh_ff    <= `TWS_BYTE_RST;
         tx_sh_ff    <= `TWS_BYTE_RST;
         rw_ff       <= 1'b0;
         addr_hi_ff  <= `TWS_AHI_RST;
         cur_addr_ff <= `TWS_ADDR_RST;
         sda_oe_ff   <= 1'b0;                                                    // [R26]
         sda_out_ff  <= 1'b0;
         busy_ff     <= 1'b0;
      end else begin
         state_ff    <= nxt_state;
         kind_ff     <= nxt_kind;
         cnt_ff      <= nxt_cnt;
         rx_sh_ff    <= nxt_rx_sh;
         tx_sh_ff    <= nxt_tx_sh;
         rw_ff       <= nxt_rw;
         addr_hi_ff  <= nxt_addr_hi;
         cur_addr_ff <= nxt_addr;                                                // [R16]
         sda_oe_ff   <= nxt_oe;
         // open drain: only ever pulls low
         sda_out_ff  <= 1'b0;
         busy_ff     <= (nxt_state != ST_IDLE);
      end
   end

   // array written in the cycle the eighth bit's byte is taken
   tws_mem u_mem (
      .sys_clk    (sys_clk),
      .wr_en      (mem_we),
      .addr       (cur_addr_ff),
      .wr_data    (rx_sh_ff),
      .rd_data_ff (rd_data)
   );

endmodule // tws_slave

`default_nettype wire

// file: include/tws_map.vh
/*
 tws_map.vh: constants of the two-wire memory slave (address widths, slave
 address fields, protection window, reset values, bit counts).
 assumes it is included by bare name from files that define nothing alike.
*/
`ifndef TWS_MAP_VH
`define TWS_MAP_VH

// memory geometry
`define TWS_ADDR_W          13
`define TWS_MEM_DEPTH       8192
`define TWS_ADDR_TOP        13'h1FFF
`define TWS_ADDR_ZERO       13'h0000
`define TWS_ADDR_ONE        13'h0001

// write protect window, upper quarter
`define TWS_PROT_BASE       13'h1800

// slave address byte fields
`define TWS_SA_TYPE_HI      7
`define TWS_SA_TYPE_LO      4
`define TWS_SA_SEL_HI       3
`define TWS_SA_SEL_LO       1
`define TWS_SA_RW_BIT       0

// high address byte: only these low bits reach the decoder
`define TWS_AHI_USED_HI     4

// bit counting within a byte
`define TWS_BITS_PER_BYTE   4'h8
`define TWS_CNT_ZERO        4'h0
`define TWS_CNT_ONE         4'h1

// reset values
`define TWS_ADDR_RST        13'h0000
`define TWS_AHI_RST         5'h00
`define TWS_BYTE_RST        8'h00

`endif

// file: hw/tws_mem.v
/*
 tws_mem: 8,192 x 8 storage array in flip-flops, one write port and one
 registered read port addressed by index.
 assumes one clock; the write enable is a single-cycle strobe from the slave.
*/
`timescale 1ns/100ps
`default_nettype none

`include "tws_map.vh"

module tws_mem (
   input  wire                    sys_clk,
   input  wire                    wr_en,
   input  wire [`TWS_ADDR_W-1:0]  addr,
   input  wire [7:0]              wr_data,
   output reg  [7:0]              rd_data_ff
);

   // contents carry no reset, like a nonvolatile array
   reg [7:0] mem_ff [0:`TWS_MEM_DEPTH-1];

   always @(posedge sys_clk) begin
      if (wr_en) begin
         mem_ff[addr] <= wr_data;
      end
      rd_data_ff <= mem_ff[addr];
   end

endmodule // tws_mem

`default_nettype wire

// file: sim/tws_slave_chk.sv
/* tws_slave_chk: port assertions for tws_slave.
   assumes scl_in and sda_in change just after a sys_clk edge. */
`timescale 1ns/100ps
`default_nettype none
`include "tws_map.vh"
module tws_slave_chk #(
   parameter [3:0] TYPE_CODE = 4'h6
) (
   input wire logic                   sys_clk,
   input wire logic                   reset,
   input wire logic                   scl_in,
   input wire logic                   sda_in,
   input wire logic                   sda_out_ff,
   input wire logic                   sda_oe_ff,
   input wire logic [2:0]             device_select_pins,
   input wire logic                   write_protect,
   input wire logic [`TWS_ADDR_W-1:0] cur_addr_ff,
   input wire logic                   busy_ff
);
   logic scl_ff;
   logic sda_ff;
   logic stop_seen;
   always @(posedge sys_clk) begin
      scl_ff <= scl_in;
      sda_ff <= sda_in;
   end
   // raw lines, so bounds below allow for the design's two sync flops
   assign stop_seen = scl_in && scl_ff && sda_in && !sda_ff;
   default clocking dc @(posedge sys_clk); endclocking
   default disable iff (reset);
   reset_state_a: assert property (disable iff (1'h0) reset |=> !sda_oe_ff && !busy_ff && cur_addr_ff == 13'h0000)
      else $error("state not cleared by reset");
   open_drain_a: assert property (sda_out_ff == 1'h0)
      else $error("data output drives high");
   oe_scl_low_a: assert property ($changed(sda_oe_ff) |-> !scl_in)
      else $error("data enable moved while clock high");
   oe_sync_lag_a: assert property ($fell(scl_in) |=> $stable(sda_oe_ff) [*2])
      else $error("data enable moved before sync delay");
   stop_release_a: assert property (stop_seen |-> ##[1:6] !sda_oe_ff)
      else $error("data line held after stop");
   stop_idle_a: assert property (stop_seen |-> ##[1:8] !busy_ff)
      else $error("not idle after stop");
   idle_quiet_a: assert property (!busy_ff |-> !sda_oe_ff)
      else $error("data line driven while idle");
   addr_move_a: assert property ($changed(cur_addr_ff) |-> !scl_in && busy_ff)
      else $error("address latch moved outside a transfer");
   cover property (stop_seen);
   cover property ($rose(sda_oe_ff));
   cover property ($past(cur_addr_ff) == 13'h1FFF && cur_addr_ff == 13'h0000);
endmodule // tws_slave_chk
bind tws_slave tws_slave_chk #(.TYPE_CODE(TYPE_CODE)) chk_u (.sys_clk(sys_clk), .reset(reset), .scl_in(scl_in),
   .sda_in(sda_in), .sda_out_ff(sda_out_ff), .sda_oe_ff(sda_oe_ff), .device_select_pins(device_select_pins),
   .write_protect(write_protect), .cur_addr_ff(cur_addr_ff), .busy_ff(busy_ff));
`default_nettype wire

// file: sim/tws_mst.sv
/* tws_mst: behavioural two-wire bus master driving clock and data.
   assumes an external pull-up resolves the data wire. */
`timescale 1ns/100ps
`default_nettype none
module tws_mst (
   input  wire logic sys_clk,
   output var  logic scl,
   output var  logic sda_low,
   input  wire logic sda
);
   initial begin
      scl = 1'h1;
      sda_low = 1'h0;
   end
   // six cycles a step, a third of a bit, well above the slave's reaction time
   task hp;
      begin
         repeat (6) @(posedge sys_clk);
         #1;
      end
   endtask
   task start;
      begin
         sda_low = 1'h0;
         hp;
         scl = 1'h1;
         hp;
         sda_low = 1'h1;
         hp;
         scl = 1'h0;
         hp;
      end
   endtask
   // only called while the slave is not driving
   task stop;
      begin
         sda_low = 1'h1;
         hp;
         scl = 1'h1;
         hp;
         sda_low = 1'h0;
         hp;
      end
   endtask
   // data moves only while clock low
   task bitx(input logic b, output logic r);
      begin
         sda_low = ~b;
         hp;
         scl = 1'h1;
         hp;
         r = sda;
         hp;
         scl = 1'h0;
      end
   endtask
   // msb first, ninth slot released or driven by ak
   task xfer(input logic [7:0] d, input logic ak, output logic [7:0] q, output logic ao);
      int i;
      begin
         for (i = 7; i >= 0; i--) bitx(d[i], q[i]);
         bitx(ak, ao);
      end
   endtask
endmodule // tws_mst
`default_nettype wire

// file: sim/tws_slave_test.sv
/* tws_slave_test: directed bench for tws_slave with a master model.
   assumes tws_slave_chk is bound to the slave. */
`timescale 1ns/100ps
`default_nettype none
`define TWS_CHK(what, exp, got) \
   checked++; \
   if ((got) !== (exp)) begin \
      mismatches++; \
      $display("wrong value %s expected %0h seen %0h", what, exp, got); \
   end
module tws_slave_test;
   localparam [3:0] DEV_TYPE = 4'h9; // arbitrary type code
   localparam [2:0] DEV_SEL = 3'h5;
   logic sys_clk, reset, write_protect, sda_oe, sda_out, busy, a;
   logic [2:0] sel_pins;
   logic [12:0] cur_addr;
   logic [7:0] q;
   wire logic scl, sda_low, sda;
   int mismatches, checked, k;
   assign sda = ~(sda_low | sda_oe); // pull-up unless someone pulls
   tws_slave #(.TYPE_CODE(DEV_TYPE)) dut_u (.sys_clk(sys_clk), .reset(reset), .scl_in(scl), .sda_in(sda),
      .sda_out_ff(sda_out), .sda_oe_ff(sda_oe), .device_select_pins(sel_pins), .write_protect(write_protect),
      .cur_addr_ff(cur_addr), .busy_ff(busy));
   tws_mst mst_u (.sys_clk(sys_clk), .scl(scl), .sda_low(sda_low), .sda(sda));
   initial begin
      sys_clk = 1'h0;
      forever #5 sys_clk = ~sys_clk;
   end
   task give_verdict;
      begin
         $display("checked %0d mismatches %0d", checked, mismatches);
         if (mismatches == 0 && checked > 0) $display("bench passed");
         else $display("bench failed");
         $finish;
      end
   endtask
   task send(input logic [7:0] d, input logic ex);
      mst_u.xfer(d, 1'h1, q, a);
      `TWS_CHK("ack slot", ex, a)
   endtask
   task get(input logic ak, input logic [7:0] ex);
      mst_u.xfer(8'hFF, ak, q, a);
      `TWS_CHK("read byte", ex, q)
   endtask
   task point(input logic [7:0] hi, input logic [7:0] lo);
      mst_u.start;
      send({DEV_TYPE, DEV_SEL, 1'h0}, 1'h0);
      send(hi, 1'h0);
      send(lo, 1'h0);
   endtask
   task ropen;
      mst_u.start;
      send({DEV_TYPE, DEV_SEL, 1'h1}, 1'h0);
   endtask
   task finish_op(input logic [12:0] ex);
      int n;
      n = 0;
      mst_u.stop;
      // look off the edge so busy is settled, not racing its own update
      while (busy !== 1'h0 && n < 20) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      `TWS_CHK("busy", 1'h0, busy)
      `TWS_CHK("address latch", ex, cur_addr)
      // a hung slave was already counted by the busy compare
      if (busy !== 1'h0) give_verdict;
   endtask
   task t_seq;
      point(8'h01, 8'h23);
      send(8'hA5, 1'h0);
      send(8'h3C, 1'h0);
      send(8'h96, 1'h0);
      finish_op(13'h0126);
      point(8'h01, 8'h23);
      ropen;
      get(1'h0, 8'hA5);
      get(1'h1, 8'h3C);
      finish_op(13'h0125);
      ropen;
      get(1'h1, 8'h96);
      finish_op(13'h0126);
      $display("test seq done");
   endtask
   task t_wrap;
      point(8'hFF, 8'hFF);
      send(8'h11, 1'h0);
      send(8'h22, 1'h0);
      finish_op(13'h0001);
      point(8'h1F, 8'hFF);
      ropen;
      get(1'h0, 8'h11);
      get(1'h1, 8'h22);
      finish_op(13'h0001);
      $display("test wrap done");
   endtask
   task t_select;
      for (k = 0; k < 8; k++) begin
         sel_pins = 3'(k);
         mst_u.start;
         send({DEV_TYPE, 3'(k), 1'h0}, 1'h0);
         mst_u.start;
         send({DEV_TYPE, 3'(k) ^ 3'h4, 1'h0}, 1'h1);
         mst_u.start;
         send({~DEV_TYPE, 3'(k), 1'h1}, 1'h1);
         mst_u.stop;
      end
      sel_pins = DEV_SEL;
      $display("test select done");
   endtask
   task t_protect;
      point(8'h18, 8'h00);
      send(8'h77, 1'h0);
      finish_op(13'h1801);
      write_protect = 1'h1;
      point(8'h17, 8'hFF);
      send(8'h5A, 1'h0);
      send(8'hC3, 1'h1);
      finish_op(13'h1800);
      point(8'h17, 8'hFF);
      ropen;
      get(1'h0, 8'h5A);
      get(1'h1, 8'h77);
      finish_op(13'h1801);
      write_protect = 1'h0;
      $display("test protect done");
   endtask
   task t_abort;
      point(8'h00, 8'h40);
      send(8'hE1, 1'h0);
      finish_op(13'h0041);
      point(8'h00, 8'h40);
      repeat (4) mst_u.bitx(1'h0, a);
      ropen;
      get(1'h1, 8'hE1);
      finish_op(13'h0041);
      point(8'h00, 8'h40);
      repeat (7) mst_u.bitx(1'h0, a);
      finish_op(13'h0040);
      ropen;
      get(1'h1, 8'hE1);
      finish_op(13'h0041);
      $display("test abort done");
   endtask
   initial begin
      repeat (90000) @(posedge sys_clk);
      mismatches++;
      give_verdict;
   end
   initial begin
      mismatches = 0;
      checked = 0;
      reset = 1'h1;
      write_protect = 1'h0;
      sel_pins = DEV_SEL;
      repeat (4) @(posedge sys_clk);
      #1 reset = 1'h0;
      repeat (4) @(posedge sys_clk);
      `TWS_CHK("reset address", 13'h0000, cur_addr)
      t_seq;
      t_wrap;
      t_select;
      t_protect;
      t_abort;
      give_verdict;
   end
endmodule // tws_slave_test
`default_nettype wire
